// ==== wsg_pkg.sv ====
package wsg_pkg;

   // register offsets on the plain register port
   localparam logic [3:0] OFF_PROG_DATA_WAIT = 4'h0;
   localparam logic [3:0] OFF_IO_WAIT        = 4'h1;
   localparam logic [3:0] OFF_WAIT_MAP       = 4'h2;
   localparam logic [3:0] OFF_STATUS         = 4'h3;

   // reset values
   localparam logic [15:0] RST_PROG_DATA_WAIT = 16'hffff;
   localparam logic [15:0] RST_IO_WAIT        = 16'hffff;
   localparam logic [4:0]  RST_WAIT_MAP       = 5'h0f;

   // wait_map_control bit positions
   localparam int MAP_PROG_BIT   = 0;
   localparam int MAP_DATA_BIT   = 1;
   localparam int MAP_IO_LO_BIT  = 2;
   localparam int MAP_IO_HI_BIT  = 3;
   localparam int MAP_BLOCK_BIT  = 4;
   localparam int MAP_WIDTH      = 5;

   // field layout of program_data_wait_states
   localparam int FIELD_WIDTH    = 2;
   localparam int DATA_FIELD_LSB = 8;

   // address bits that pick a field
   localparam int PD_BLOCK_MSB   = 15;
   localparam int PD_BLOCK_LSB   = 14;
   localparam int IO_PAIR_MSB    = 3;
   localparam int IO_PAIR_LSB    = 1;
   localparam int IO_BLOCK_MSB   = 15;
   localparam int IO_BLOCK_LSB   = 13;

   // data-space window onto the i/o ports
   localparam logic [15:0] MMIO_BASE = 16'h0050;
   localparam logic [15:0] MMIO_LAST = 16'h005f;

   // wait counts
   localparam int             WAIT_WIDTH = 3;
   localparam logic [2:0]     WAIT_MAX   = 3'h7;

   typedef enum logic [1:0] {
      SPACE_PROG = 2'b00,
      SPACE_DATA = 2'b01,
      SPACE_IO   = 2'b10
   } wsg_space_t;

endpackage : wsg_pkg

// ==== wsg_field_map.sv ====
`timescale 1ns/100ps
module wsg_field_map (
   input  wire logic [1:0] field,
   input  wire logic       log_map,
   output logic      [2:0] wait_count
);

   always_comb begin
      case (log_map)
         1'b0:    wait_count = {1'b0, field};
         1'b1:    wait_count = {&field, field[1], |field};
         default: wait_count = 3'h0;
      endcase
   end

endmodule : wsg_field_map

// ==== wsg_wait_gen.sv ====
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
// How it works
// - io space select marks every port access
// - data addresses 50h-5Fh reach i/o ports
// - software waits stretch cycles zero to seven
// - all fields zero stops the wait counter
// - low byte program, high byte data fields
// - address bits 15:14 pick program/data field
// - block mode clear: port bits 3:1 pick
// - block mode set: address bits 15:13 pick
// - on-chip accesses never get wait states
// - map bit zero: waits equal field value
// - map bit one: 0,1,3,7 waits
// - map bits: prog, data, io low, io high, block
// - external access loads counter, nonzero stalls cpu
// - stall until counter zero and ready high
// - counter and ready both drive cpu wait
// - ready sampled on falling clock edge
// - ready looked at only in last cycle
module wsg_wait_gen (
   input  wire logic        clk,
   input  wire logic        rstn,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [15:0] reg_rdata,
   // cpu access side
   input  wire logic        access_start,
   input  wire logic [1:0]  access_space,
   input  wire logic [15:0] access_addr,
   input  wire logic        access_external,
   output logic             cpu_wait,
   // external bus side
   input  wire logic        ext_ready,
   output logic             io_space_select,
   output logic             machine_clock_output,
   output logic             wait_clock_on
);

   logic [15:0] pd_wait_r;
   logic [15:0] io_wait_r;
   logic [4:0]  map_r;
   logic [15:0] rdata_r;
   logic [2:0]  cnt_r;
   logic [2:0]  cnt_nxt;
   logic        busy_r;
   logic        io_r;
   logic        rdy_meta_r;
   logic        rdy_sync_r;

   wire         start_ok;
   wire         start_ext;
   wire         is_prog;
   wire         is_data;
   wire         in_mmio;
   wire         is_io;
   wire         block_mode;
   wire  [1:0]  pd_idx;
   wire  [2:0]  io_idx;
   wire  [3:0]  pd_bit;
   wire  [3:0]  io_bit;
   wire  [1:0]  prog_field;
   wire  [1:0]  data_field;
   wire  [1:0]  io_field;
   wire  [1:0]  sel_field;
   wire         sel_map;
   wire  [2:0]  wait_sel;
   wire  [2:0]  load_val;
   wire         gen_active;
   wire         wait_now;
   wire         dec_wait;
   wire         sel_pd;
   wire         sel_io;
   wire         sel_map_reg;
   wire         sel_stat;
   wire  [15:0] status_word;
   wire  [15:0] rd_mux;

   // access decode
   assign start_ok   = access_start & ~busy_r;
   assign is_prog    = access_space == wsg_pkg::SPACE_PROG;
   assign is_data    = access_space == wsg_pkg::SPACE_DATA;
   assign in_mmio    = is_data
                       & (access_addr >= wsg_pkg::MMIO_BASE)
                       & (access_addr <= wsg_pkg::MMIO_LAST);
   assign is_io      = (access_space == wsg_pkg::SPACE_IO) | in_mmio;
   // mapped ports are always off chip; everything else as the core says
   assign start_ext  = start_ok & (access_external | in_mmio);

   // field selection
   assign block_mode = map_r[wsg_pkg::MAP_BLOCK_BIT];
   assign pd_idx     = access_addr[wsg_pkg::PD_BLOCK_MSB:wsg_pkg::PD_BLOCK_LSB];
   assign io_idx     = block_mode
                       ? access_addr[wsg_pkg::IO_BLOCK_MSB:wsg_pkg::IO_BLOCK_LSB]
                       : access_addr[wsg_pkg::IO_PAIR_MSB:wsg_pkg::IO_PAIR_LSB];
   assign pd_bit     = {1'b0, pd_idx, 1'b0};
   assign io_bit     = {io_idx, 1'b0};
   assign prog_field = pd_wait_r[pd_bit +: wsg_pkg::FIELD_WIDTH];
   assign data_field = pd_wait_r[(pd_bit + 4'(wsg_pkg::DATA_FIELD_LSB))
                                 +: wsg_pkg::FIELD_WIDTH];
   assign io_field   = io_wait_r[io_bit +: wsg_pkg::FIELD_WIDTH];

   assign sel_field  = is_io   ? io_field   :
                       is_prog ? prog_field :
                                 data_field;
   assign sel_map    = is_io   ? (io_idx[2] ? map_r[wsg_pkg::MAP_IO_HI_BIT]
                                            : map_r[wsg_pkg::MAP_IO_LO_BIT]) :
                       is_prog ? map_r[wsg_pkg::MAP_PROG_BIT] :
                                 map_r[wsg_pkg::MAP_DATA_BIT];

   wsg_field_map u_field_map (
      .field      (sel_field),
      .log_map    (sel_map),
      .wait_count (wait_sel)
   );

   // wait counter
   // all fields zero means no access can need software waits
   assign gen_active = (|pd_wait_r) | (|io_wait_r);
   assign wait_clock_on = gen_active;

   // start cycle is the first wait cycle, so load one less
   assign load_val   = (wait_sel != 3'h0) ? (wait_sel - 3'h1) : 3'h0;
   assign wait_now   = gen_active & (wait_sel != 3'h0);
   assign dec_wait   = busy_r & (cnt_r != 3'h0);

   // ready counts only once the counter is spent
   assign cpu_wait   = start_ext ? (wait_now | ~rdy_sync_r)
                                 : (dec_wait | (busy_r & ~rdy_sync_r));

   always_comb begin
      cnt_nxt = cnt_r;
      if (start_ext) begin
         cnt_nxt = gen_active ? load_val : 3'h0;
      end else if (cnt_r != 3'h0) begin
         cnt_nxt = cnt_r - 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r  <= 3'h0;
         busy_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= cpu_wait;
      end
   end

   // i/o space select
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         io_r <= 1'b0;
      end else if (start_ok) begin
         io_r <= is_io;
      end
   end

   assign io_space_select = start_ok ? is_io : (busy_r & io_r);

   // ready pin: first stage on the falling edge, second on the rising
   assign machine_clock_output = clk;

   always_ff @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         rdy_meta_r <= 1'b1;
      end else begin
         rdy_meta_r <= ext_ready;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdy_sync_r <= 1'b1;
      end else begin
         rdy_sync_r <= rdy_meta_r;
      end
   end

   // register port
   assign sel_pd      = reg_addr == wsg_pkg::OFF_PROG_DATA_WAIT;
   assign sel_io      = reg_addr == wsg_pkg::OFF_IO_WAIT;
   assign sel_map_reg = reg_addr == wsg_pkg::OFF_WAIT_MAP;
   assign sel_stat    = reg_addr == wsg_pkg::OFF_STATUS;

   assign status_word = {11'h000, cnt_r, busy_r, gen_active};

   assign rd_mux = sel_pd      ? pd_wait_r :
                   sel_io      ? io_wait_r :
                   sel_map_reg ? {11'h000, map_r} :
                   sel_stat    ? status_word :
                                 16'h0000;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pd_wait_r <= wsg_pkg::RST_PROG_DATA_WAIT;
         io_wait_r <= wsg_pkg::RST_IO_WAIT;
         map_r     <= wsg_pkg::RST_WAIT_MAP;
      end else if (reg_we) begin
         if (sel_pd) begin
            pd_wait_r <= reg_wdata;
         end
         if (sel_io) begin
            io_wait_r <= reg_wdata;
         end
         if (sel_map_reg) begin
            map_r <= reg_wdata[wsg_pkg::MAP_WIDTH-1:0];
         end
      end
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= reg_re ? rd_mux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_r;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   wait_start_a: assert property (
      start_ext && gen_active && (wait_sel != 3'h0) |-> cpu_wait
   ) else $error("nonzero wait field did not stall the start cycle");

   on_chip_a: assert property (
      start_ok && !access_external && !in_mmio && rdy_sync_r |-> !cpu_wait
   ) else $error("on-chip access was stalled");

   count_down_a: assert property (
      busy_r && (cnt_r != 3'h0) && !start_ext |=> cnt_r == $past(cnt_r) - 3'h1
   ) else $error("wait counter did not drop by one");

   ready_hold_a: assert property (
      busy_r && (cnt_r == 3'h0) && !rdy_sync_r |-> cpu_wait
   ) else $error("access released while ready low");

   ready_late_a: assert property (
      dec_wait && rdy_sync_r |-> cpu_wait
   ) else $error("ready ended software waits early");

   seven_waits_a: assert property (
      start_ext && gen_active && (wait_sel == wsg_pkg::WAIT_MAX) |-> cpu_wait [*7]
   ) else $error("seven wait states not inserted");

   exact_waits_a: assert property (
      start_ext && gen_active && (wait_sel == 3'h2)
      |-> cpu_wait ##1 cpu_wait ##1 (cpu_wait == !rdy_sync_r)
   ) else $error("two wait states overran");

   io_select_a: assert property (
      start_ok && (access_space == wsg_pkg::SPACE_IO) |-> io_space_select
   ) else $error("i/o access without space select");

   mmio_select_a: assert property (
      start_ok && is_data && (access_addr[15:4] == 12'h005) |-> io_space_select
   ) else $error("mapped port missed space select");

   gate_off_a: assert property (
      start_ext && !gen_active |=> cnt_r == 3'h0
   ) else $error("counter loaded with generator off");

   map_read_a: assert property (
      reg_re && sel_map_reg |=> reg_rdata == {11'h000, $past(map_r)}
   ) else $error("wait map readback wrong");

   block_pick_a: assert property (
      block_mode && start_ok && (access_space == wsg_pkg::SPACE_IO)
      |-> io_field == io_wait_r[{access_addr[15:13], 1'b0} +: 2]
   ) else $error("block mode field pick wrong");

   direct_three_a: assert property (
      start_ext && !sel_map && (sel_field == 2'b11)
      |-> cpu_wait [*3] ##1 (cnt_r == 3'h0)
   ) else $error("direct field three not three waits");

   mapped_three_a: assert property (
      start_ext && sel_map && (sel_field == 2'b10)
      |=> cnt_r == 3'h2
   ) else $error("mapped field two not three waits");

   single_wait_a: assert property (
      start_ext && (sel_field == 2'b01)
      |-> cpu_wait ##1 (cnt_r == 3'h0)
   ) else $error("field one not one wait");

   zero_field_a: assert property (
      start_ext && (sel_field == 2'b00) && rdy_sync_r
      |-> !cpu_wait
   ) else $error("zero field stalled");

   prog_pick_a: assert property (
      start_ok && is_prog
      |-> prog_field == pd_wait_r[{access_addr[15:14], 1'b0} +: 2]
   ) else $error("program field pick wrong");

   data_pick_a: assert property (
      start_ok && is_data
      |-> data_field == pd_wait_r[{1'b1, access_addr[15:14], 1'b0} +: 2]
   ) else $error("data field pick wrong");

   pair_pick_a: assert property (
      !block_mode && start_ok && (access_space == wsg_pkg::SPACE_IO)
      |-> io_field == io_wait_r[{access_addr[3:1], 1'b0} +: 2]
   ) else $error("port pair field pick wrong");

   io_low_map_a: assert property (
      start_ok && is_io && !(block_mode ? access_addr[15] : access_addr[3])
      |-> sel_map == map_r[wsg_pkg::MAP_IO_LO_BIT]
   ) else $error("lower i/o half used wrong map bit");

   io_high_map_a: assert property (
      start_ok && is_io && (block_mode ? access_addr[15] : access_addr[3])
      |-> sel_map == map_r[wsg_pkg::MAP_IO_HI_BIT]
   ) else $error("upper i/o half used wrong map bit");

   release_a: assert property (
      busy_r && (cnt_r == 3'h0) && rdy_sync_r
      |-> !cpu_wait
   ) else $error("access held after counter spent and ready high");

   either_stall_a: assert property (
      start_ext && !rdy_sync_r
      |-> cpu_wait
   ) else $error("low ready did not stall start");

   ready_sync_a: assert property (
      rdy_sync_r == $past(rdy_meta_r)
   ) else $error("ready second stage lost first stage");

   io_hold_a: assert property (
      busy_r && io_r
      |-> io_space_select
   ) else $error("space select dropped during stalled i/o access");

   internal_idle_a: assert property (
      start_ok && !start_ext
      |=> cnt_r == 3'h0
   ) else $error("on-chip access loaded the counter");

endmodule : wsg_wait_gen

// ==== wsg_ext_device.sv ====
`timescale 1ns/100ps
// slow external part: holds ready low for a set number of cycles per access
module wsg_ext_device (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       bus_strobe,
   input  wire logic       chip_sel,
   input  wire logic [3:0] slow_cycles,
   output logic            ext_ready
);
   logic [3:0] hold_r;
   wire        periph_en;

   // strobe and chip select together enable the part
   assign periph_en = bus_strobe & chip_sel;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_r <= 4'h0;
      end else if (periph_en) begin
         hold_r <= slow_cycles;
      end else if (hold_r != 4'h0) begin
         hold_r <= hold_r - 4'h1;
      end
   end

   // settles right after the rising edge, stable at the falling edge
   assign ext_ready = (hold_r == 4'h0) && !(periph_en && slow_cycles != 4'h0);
endmodule : wsg_ext_device

// ==== wsg_wait_gen_test.sv ====
`timescale 1ns/100ps
module wsg_wait_gen_test;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_we = 1'b0;
   logic        reg_re = 1'b0;
   logic [15:0] reg_rdata;
   logic        access_start = 1'b0;
   logic [1:0]  access_space = 2'b00;
   logic [15:0] access_addr = 16'h0000;
   logic        access_external = 1'b0;
   logic        cpu_wait;
   logic        ext_ready;
   logic        io_space_select;
   logic        machine_clock_output;
   logic        wait_clock_on;
   logic [3:0]  slow_cycles = 4'h0;
   int          fail_count = 0;
   int          comparisons = 0;

   always #25 clk = ~clk;

   wsg_wait_gen wsg_wait_gen_inst (
      .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .access_start(access_start), .access_space(access_space),
      .access_addr(access_addr), .access_external(access_external),
      .cpu_wait(cpu_wait), .ext_ready(ext_ready), .io_space_select(io_space_select),
      .machine_clock_output(machine_clock_output), .wait_clock_on(wait_clock_on));

   wsg_ext_device wsg_ext_device_inst (
      .clk(clk), .rstn(rstn), .bus_strobe(access_start), .chip_sel(access_external),
      .slow_cycles(slow_cycles), .ext_ready(ext_ready));

   task automatic results;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask : reg_read

   // counts the cycles in which the cpu is held, start cycle included
   task automatic access(input logic [1:0] sp, input logic [15:0] a, input logic ex,
                         input logic io_exp, output logic [15:0] n);
      n = 16'h0000;
      @(posedge clk);
      access_start <= 1'b1;
      access_space <= sp;
      access_addr <= a;
      access_external <= ex;
      #1 check(16'(io_space_select), 16'(io_exp));
      while (cpu_wait === 1'b1 && n < 16'h0028) begin
         n = n + 16'h0001;
         @(posedge clk);
         access_start <= 1'b0;
         #1;
         check(16'(io_space_select), 16'(io_exp));
      end
      if (n >= 16'h0028) begin
         fail_count++;
         results();
      end
      if (n == 16'h0000) begin
         @(posedge clk);
         access_start <= 1'b0;
      end
   endtask : access

   task automatic acc_chk(input logic [1:0] sp, input logic [15:0] a, input logic ex,
                          input logic io_exp, input logic [15:0] exp);
      logic [15:0] n;
      access(sp, a, ex, io_exp, n);
      check(n, exp);
   endtask : acc_chk

   task automatic t_reset;
      reg_read(wsg_pkg::OFF_PROG_DATA_WAIT, 16'hffff);
      reg_read(wsg_pkg::OFF_IO_WAIT, 16'hffff);
      reg_read(wsg_pkg::OFF_WAIT_MAP, 16'h000f);
      reg_read(4'h4, 16'h0000);
      reg_read(wsg_pkg::OFF_STATUS, 16'h0001);
      check(16'(wait_clock_on), 16'h0001);
      check(16'(machine_clock_output), 16'h0001);
      #25 check(16'(machine_clock_output), 16'h0000);
      acc_chk(wsg_pkg::SPACE_PROG, 16'h0000, 1'b1, 1'b0, 16'h0007);
   endtask : t_reset

   task automatic t_map;
      logic [15:0] exp;
      for (int m = 0; m < 2; m++) begin
         for (int f = 0; f < 4; f++) begin
            exp = (m == 0) ? 16'(f) : (f == 3) ? 16'h0007 : (f == 2) ? 16'h0003 : 16'(f);
            reg_write(wsg_pkg::OFF_WAIT_MAP, 16'(m));
            reg_write(wsg_pkg::OFF_PROG_DATA_WAIT, 16'(f) << 6);
            acc_chk(wsg_pkg::SPACE_PROG, 16'hc000, 1'b1, 1'b0, exp);
         end
      end
   endtask : t_map

   task automatic t_spaces;
      reg_write(wsg_pkg::OFF_WAIT_MAP, 16'h0000);
      reg_write(wsg_pkg::OFF_PROG_DATA_WAIT, 16'h0880);
      acc_chk(wsg_pkg::SPACE_PROG, 16'hc000, 1'b0, 1'b0, 16'h0000);
      acc_chk(wsg_pkg::SPACE_PROG, 16'h8000, 1'b1, 1'b0, 16'h0000);
      acc_chk(wsg_pkg::SPACE_DATA, 16'h4000, 1'b1, 1'b0, 16'h0002);
      acc_chk(wsg_pkg::SPACE_DATA, 16'hc000, 1'b1, 1'b0, 16'h0000);
      reg_write(wsg_pkg::OFF_WAIT_MAP, 16'h0008);
      reg_write(wsg_pkg::OFF_IO_WAIT, 16'h0c00);
      acc_chk(wsg_pkg::SPACE_IO, 16'h001a, 1'b1, 1'b1, 16'h0007);
      acc_chk(wsg_pkg::SPACE_IO, 16'h0012, 1'b1, 1'b1, 16'h0000);
      acc_chk(wsg_pkg::SPACE_DATA, 16'h005a, 1'b0, 1'b1, 16'h0007);
      reg_write(wsg_pkg::OFF_WAIT_MAP, 16'h0000);
      acc_chk(wsg_pkg::SPACE_IO, 16'hfffa, 1'b1, 1'b1, 16'h0003);
      reg_write(wsg_pkg::OFF_WAIT_MAP, 16'h0018);
      acc_chk(wsg_pkg::SPACE_IO, 16'ha000, 1'b1, 1'b1, 16'h0007);
      acc_chk(wsg_pkg::SPACE_IO, 16'h001a, 1'b1, 1'b1, 16'h0000);
      reg_read(wsg_pkg::OFF_WAIT_MAP, 16'h0018);
   endtask : t_spaces

   task automatic t_ready;
      logic [15:0] n;
      reg_write(wsg_pkg::OFF_WAIT_MAP, 16'h0000);
      reg_write(wsg_pkg::OFF_PROG_DATA_WAIT, 16'h0003);
      slow_cycles <= 4'h6;
      access(wsg_pkg::SPACE_PROG, 16'h0100, 1'b1, 1'b0, n);
      check(16'(n >= 16'h0006 && n <= 16'h000c), 16'h0001);
      slow_cycles <= 4'h1;
      acc_chk(wsg_pkg::SPACE_PROG, 16'h0100, 1'b1, 1'b0, 16'h0003);
      slow_cycles <= 4'h0;
   endtask : t_ready

   task automatic t_gate;
      reg_write(wsg_pkg::OFF_PROG_DATA_WAIT, 16'h0000);
      reg_write(wsg_pkg::OFF_IO_WAIT, 16'h0000);
      #1 check(16'(wait_clock_on), 16'h0000);
      acc_chk(wsg_pkg::SPACE_IO, 16'h001a, 1'b1, 1'b1, 16'h0000);
      reg_read(wsg_pkg::OFF_STATUS, 16'h0000);
      reg_write(wsg_pkg::OFF_IO_WAIT, 16'h4000);
      #1 check(16'(wait_clock_on), 16'h0001);
   endtask : t_gate

   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_map();
      t_spaces();
      t_ready();
      t_gate();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      results();
   end
endmodule : wsg_wait_gen_test
